// ===== inc/sgcn_defines.svh
/*
 Offsets, field positions, reset values and timing counts for the
 global control nine register bank.
 Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef SGCN_DEFINES_SVH
`define SGCN_DEFINES_SVH

// ============================================================
// Register map
`define SGCN_GCN_INDEX      8'h0b
`define SGCN_GCN_ADDR       12'h02c
`define SGCN_STATUS_ADDR    12'h030

// ============================================================
// Field positions
`define SGCN_REFCLK_EDGE_BIT 6
`define SGCN_POWER_SAVE_BIT  3
`define SGCN_LED_MODE_BIT    1
`define SGCN_READ_EDGE_BIT   0

// ============================================================
// Reset values and masks
`define SGCN_GCN_RESET      8'h00
`define SGCN_GCN_WMASK      8'h4b

// ============================================================
// LED codes, mode 0 (bits 2,1,0)
`define SGCN_LED_100_FULL   3'h0
`define SGCN_LED_100_HALF   3'h2
`define SGCN_LED_10         3'h1

// ============================================================
// Timing
`define SGCN_STRAP_HOLD_CYCLES 2'h2

`endif

// ===== inc/sgcn_pkg.sv
/*
 Types for the global control nine register bank.
 Assumes sgcn_defines.svh on the include path.
*/
`default_nettype none
package sgcn_pkg;
   typedef struct packed {
      logic refclk_falling;
      logic power_save;
      logic led_mode;
      logic read_rising;
   } sgcn_ctrl_type;

   typedef struct packed {
      logic link_up;
      logic speed_100;
      logic full_duplex;
   } sgcn_link_type;

   typedef enum logic [1:0] {
      SGCN_IDLE,
      SGCN_SETUP,
      SGCN_ACCESS
   } sgcn_apb_state_type;
endpackage
`default_nettype wire

// ===== src/sgcn_strap_capture.sv
/*
 Catches the LED mode strap once after reset release.
 Assumes the strap pin is synchronous to pclk and stable after reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sgcn_defines.svh"
module sgcn_strap_capture (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic strap_level,
   output logic      strap_valid,
   output logic      strap_value
);
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic       value_reg;
   logic       value_next;

   // ============================================================
   // Capture after release; never from the async reset branch
   always_comb begin
      count_next = count_reg;
      value_next = value_reg;
      if (count_reg != `SGCN_STRAP_HOLD_CYCLES) begin
         count_next = count_reg + 2'h1;
         value_next = strap_level;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 2'h0;
         value_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         value_reg <= value_next;
      end
   end

   assign strap_valid = (count_reg == `SGCN_STRAP_HOLD_CYCLES);
   assign strap_value = value_reg;

   strap_settles_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(strap_valid) |-> ##1 strap_valid [*4])
      else $error("strap valid dropped after capture");
endmodule
`default_nettype wire

// ===== src/sgcn_led_encoder.sv
/*
 Per-port LED encoder for LED mode 0 and mode 1.
 Assumes link status is synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sgcn_defines.svh"
module sgcn_led_encoder #(
   parameter int PORTS = 5
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  led_mode,
   input  wire sgcn_pkg::sgcn_link_type link_status [PORTS],
   input  wire logic [PORTS-1:0]      activity,
   output logic      [3*PORTS-1:0]    per_port_led_outputs
);
   import sgcn_pkg::*;

   logic [3*PORTS-1:0] led_reg;
   logic [3*PORTS-1:0] led_next;

   // ============================================================
   // Encoding; LEDs are active low, so 0 lights
   always_comb begin
      led_next = '1;
      for (int p = 0; p < PORTS; p++) begin
         if (link_status[p].link_up) begin
            if (!led_mode) begin
               if (!link_status[p].speed_100)
                  led_next[3*p +: 3] = `SGCN_LED_10;
               else if (link_status[p].full_duplex)
                  led_next[3*p +: 3] = `SGCN_LED_100_FULL;
               else
                  led_next[3*p +: 3] = `SGCN_LED_100_HALF;
            end else begin
               // Mode 1 encoding is kept simple: link/act, speed, duplex
               led_next[3*p +: 3] = {activity[p], !link_status[p].speed_100,
                                     !link_status[p].full_duplex};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         led_reg <= '1;
      else
         led_reg <= led_next;
   end

   assign per_port_led_outputs = led_reg;

   led_mode0_10_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!led_mode && link_status[0].link_up && !link_status[0].speed_100)
      |=> per_port_led_outputs[2:0] == `SGCN_LED_10)
      else $error("mode 0 10M code wrong");
   led_mode0_hd_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!led_mode && link_status[0].link_up && link_status[0].speed_100
       && !link_status[0].full_duplex)
      |=> per_port_led_outputs[2:0] == `SGCN_LED_100_HALF)
      else $error("mode 0 100M half code wrong");
endmodule
`default_nettype wire

// ===== src/sgcn_global_control.sv
/*
 Global control nine register with APB slave, strap capture and LED
 encoding. Assumes an APB3 master on pclk and link status from the MACs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sgcn_defines.svh"
module sgcn_global_control #(
   parameter int   PORTS           = 5,
   parameter logic REDUCED_PORT    = 1'b1
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic                      pready,
   output logic      [31:0]          prdata,
   output logic                      pslverr,
   input  wire logic                 led_mode_strap_pin,
   input  wire sgcn_pkg::sgcn_link_type link_status [PORTS],
   input  wire logic [PORTS-1:0]     activity,
   output logic      [3*PORTS-1:0]   per_port_led_outputs,
   output sgcn_pkg::sgcn_ctrl_type   control,
   output logic                      mac_sample_on_rise,
   output logic                      mgmt_read_on_rise,
   output logic                      phy_power_save
);
   import sgcn_pkg::*;

   // ============================================================
   // Register state
   logic [7:0]  gcn_reg;
   logic [7:0]  gcn_next;
   logic        strap_done_reg;
   logic        strap_done_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        strap_valid;
   logic        strap_value;
   logic        access;
   logic        hit_gcn;
   logic        hit_status;
   logic [7:0]  wmask;

   sgcn_strap_capture u_strap (
      .pclk        (pclk),
      .presetn     (presetn),
      .strap_level (led_mode_strap_pin),
      .strap_valid (strap_valid),
      .strap_value (strap_value)
   );

   assign access     = psel && penable;
   assign hit_gcn    = (paddr == `SGCN_GCN_ADDR);
   assign hit_status = (paddr == `SGCN_STATUS_ADDR);

   // Full-port variant freezes the edge bit; bit 7 never writable
   assign wmask = REDUCED_PORT ? `SGCN_GCN_WMASK
                               : (`SGCN_GCN_WMASK & ~(8'h01 << `SGCN_REFCLK_EDGE_BIT));

   // ============================================================
   // Next-state logic
   always_comb begin
      gcn_next        = gcn_reg;
      strap_done_next = strap_done_reg;
      rdata_next      = 32'h0000_0000;
      // Strap load happens once; a software write in that cycle wins
      if (strap_valid && !strap_done_reg) begin
         gcn_next[`SGCN_LED_MODE_BIT] = strap_value;
         strap_done_next              = 1'b1;
      end
      if (access && pwrite && hit_gcn && pstrb[0]) begin
         gcn_next = (gcn_reg & ~wmask) | (pwdata[7:0] & wmask);
      end
      if (access && !pwrite) begin
         if (hit_gcn)
            rdata_next = {24'h00_0000, gcn_reg & wmask};
         else if (hit_status)
            rdata_next = {30'h0000_0000, strap_done_reg, strap_value};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcn_reg        <= `SGCN_GCN_RESET;
         strap_done_reg <= 1'b0;
         rdata_reg      <= 32'h0000_0000;
      end else begin
         gcn_reg        <= gcn_next;
         strap_done_reg <= strap_done_next;
         rdata_reg      <= rdata_next;
      end
   end

   // Zero-wait slave; read data is the live register value
   assign pready  = 1'b1;
   assign prdata  = access ? (hit_gcn ? {24'h00_0000, gcn_reg & wmask}
                                      : (hit_status ? {30'h0000_0000, strap_done_reg,
                                                       strap_value} : 32'h0000_0000))
                           : rdata_reg;
   assign pslverr = access && !hit_gcn && !hit_status;

   // ============================================================
   // Control outputs
   assign control.refclk_falling = gcn_reg[`SGCN_REFCLK_EDGE_BIT] && REDUCED_PORT;
   assign control.power_save     = gcn_reg[`SGCN_POWER_SAVE_BIT];
   assign control.led_mode       = gcn_reg[`SGCN_LED_MODE_BIT];
   assign control.read_rising    = gcn_reg[`SGCN_READ_EDGE_BIT];
   assign mac_sample_on_rise     = !control.refclk_falling;
   assign mgmt_read_on_rise      = control.read_rising;
   assign phy_power_save         = control.power_save;

   sgcn_led_encoder #(
      .PORTS (PORTS)
   ) u_led (
      .pclk                 (pclk),
      .presetn              (presetn),
      .led_mode             (control.led_mode),
      .link_status          (link_status),
      .activity             (activity),
      .per_port_led_outputs (per_port_led_outputs)
   );

   // ============================================================
   // Checks
   sequence gcn_write_s;
      access && pwrite && hit_gcn && pstrb[0];
   endsequence

   refclk_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      gcn_write_s ##0 REDUCED_PORT |=> control.refclk_falling
      == $past(pwdata[`SGCN_REFCLK_EDGE_BIT]))
      else $error("refclk edge bit not written");
   refclk_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
      !REDUCED_PORT |-> !gcn_reg[`SGCN_REFCLK_EDGE_BIT])
      else $error("edge bit changed on full port");
   led_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      gcn_write_s |=> control.led_mode == $past(pwdata[`SGCN_LED_MODE_BIT]))
      else $error("led mode not written");
   strap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(strap_done_reg) && !$past(access && pwrite && hit_gcn)
      |-> control.led_mode == $past(strap_value))
      else $error("strap not loaded into led mode");
   read_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      gcn_write_s |=> mgmt_read_on_rise == $past(pwdata[`SGCN_READ_EDGE_BIT]))
      else $error("read edge bit not written");
   power_save_a: assert property (@(posedge pclk) disable iff (!presetn)
      gcn_write_s |=> phy_power_save == $past(pwdata[`SGCN_POWER_SAVE_BIT]))
      else $error("power save bit not written");
   top_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pwrite && hit_gcn |-> prdata[31:7] == 25'h0 && prdata[5:4] == 2'h0
      && prdata[2] == 1'b0)
      else $error("reserved bits read nonzero");
   hold_value_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_done_reg && !(access && pwrite) |=> $stable(gcn_reg))
      else $error("register changed without a write");
endmodule
`default_nettype wire

// ===== tb/sgcn_apb_host.sv
/*
 APB master model standing in for the host processor.
 Assumes one pclk domain and a slave that may add wait states.
*/
`timescale 1ns/10ps
`default_nettype none
module sgcn_apb_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end

   // ============================================================
   // One transfer; waits on pready, bench timeout ends a hang
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Address and write data driven to inverse so stale values never pass
      pwdata <= ~wd;
      paddr <= ~addr;
   endtask
endmodule
`default_nettype wire

// ===== tb/switch_global_control_nine_bench.sv
/*
 Self-checking bench for the global control nine register bank.
 Assumes the design files and sgcn_defines.svh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sgcn_defines.svh"
module switch_global_control_nine_bench;
   import sgcn_pkg::*;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 strap = 1'b0;
   logic                 psel, penable, pwrite, pready, pslverr;
   logic          [11:0] paddr;
   logic          [31:0] pwdata, prdata, rd;
   logic          [3:0]  pstrb;
   logic                 err;
   logic          [31:0] prdata_full;
   sgcn_link_type        link_st [5];
   logic          [4:0]  act = 5'h00;
   logic          [14:0] leds;
   sgcn_ctrl_type        ctl, ctl_full;
   logic                 mac_rise, mgmt_rise, psave;
   int                   n_errors = 0;
   int                   n_checks = 0;
   int                   cycles = 0;

   initial begin
      forever #2 pclk = ~pclk;
   end
   initial begin
      for (int i = 0; i < 5; i++) link_st[i] = '0;
   end

   sgcn_apb_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb));
   sgcn_global_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .led_mode_strap_pin(strap), .link_status(link_st),
      .activity(act), .per_port_led_outputs(leds), .control(ctl),
      .mac_sample_on_rise(mac_rise), .mgmt_read_on_rise(mgmt_rise), .phy_power_save(psave));
   // Full-port variant shares the bus; only its control outputs and read data are watched
   sgcn_global_control #(.REDUCED_PORT(1'b0)) DUT_full (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(), .prdata(prdata_full), .pslverr(), .led_mode_strap_pin(strap),
      .link_status(link_st), .activity(act), .per_port_led_outputs(), .control(ctl_full),
      .mac_sample_on_rise(), .mgmt_read_on_rise(), .phy_power_save());

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         end_sim();
      end
   end

   // ============================================================
   // Scenarios
   task automatic do_reset(input logic level);
      @(posedge pclk);
      presetn <= 1'b0;
      strap <= level;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Strap loads on the third edge after release
      repeat (4) @(posedge pclk);
   endtask

   task automatic reset_values();
      host.xfer(1'b0, `SGCN_GCN_ADDR, 32'h0, rd, err);
      check(rd, 32'h0000_0000);
      check(err, 1'b0);
      #1 check(mac_rise, 1'b1);
      check(mgmt_rise, 1'b0);
      host.xfer(1'b0, `SGCN_STATUS_ADDR, 32'h0, rd, err);
      check(rd, 32'h0000_0002);
   endtask

   task automatic write_all();
      host.xfer(1'b1, `SGCN_GCN_ADDR, 32'h0000_00ff, rd, err);
      #1 check(mac_rise, 1'b0);
      check(ctl, 4'hf);
      check({mgmt_rise, psave}, 2'h3);
      check(ctl_full.refclk_falling, 1'b0);
      host.xfer(1'b0, `SGCN_GCN_ADDR, 32'h0, rd, err);
      check(rd, 32'h0000_004b);
      // Full-port copy holds its registered read word for one cycle once the bus idles
      #1 check(prdata_full, 32'h0000_000b);
      host.xfer(1'b1, `SGCN_GCN_ADDR, 32'h0000_0000, rd, err);
      #1 check({mac_rise, mgmt_rise, psave, ctl.led_mode}, 4'h8);
   endtask

   task automatic unmapped();
      host.xfer(1'b1, 12'h040, 32'h0000_00ff, rd, err);
      check(err, 1'b1);
      host.xfer(1'b0, 12'h040, 32'h0, rd, err);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      #1 check(ctl, 4'h0);
   endtask

   task automatic led_mode0();
      // Ports 0..4: 100 full, 100 half, 10 full, 10 half, 100 full
      @(posedge pclk);
      link_st[0] <= 3'b111;
      link_st[1] <= 3'b110;
      link_st[2] <= 3'b101;
      link_st[3] <= 3'b100;
      link_st[4] <= 3'b111;
      repeat (3) @(posedge pclk);
      #1 check(leds, 15'b000_001_001_010_000);
      // Port 0 walks 10M, 100M half, then link down
      @(posedge pclk);
      link_st[0] <= 3'b101;
      repeat (2) @(posedge pclk);
      #1 check(leds[2:0], 3'h1);
      @(posedge pclk);
      link_st[0] <= 3'b110;
      repeat (2) @(posedge pclk);
      #1 check(leds[2:0], 3'h2);
      @(posedge pclk);
      link_st[0] <= 3'b011;
      act <= 5'h10;
      repeat (2) @(posedge pclk);
      #1 check(leds[2:0], 3'h7);
   endtask

   task automatic strap_high();
      do_reset(1'b1);
      host.xfer(1'b0, `SGCN_GCN_ADDR, 32'h0, rd, err);
      check(rd, 32'h0000_0002);
      host.xfer(1'b0, `SGCN_STATUS_ADDR, 32'h0, rd, err);
      check(rd, 32'h0000_0003);
      // Mode 1 is {activity, not 100M, not full}; port 0 is down
      #1 check(leds, 15'b100_011_010_001_111);
      host.xfer(1'b1, `SGCN_GCN_ADDR, 32'h0000_0000, rd, err);
      #1 check(ctl.led_mode, 1'b0);
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      reset_values();
      write_all();
      unmapped();
      led_mode0();
      strap_high();
      end_sim();
   end
endmodule
`default_nettype wire
